/* File: design/ccsync_top.sv */
// Clock distribution sync control with APB register slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ccsync_regs.svh"

module ccsync_top
  import ccsync_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        freq_locked,
  input  wire logic        phase_locked,
  input  wire logic [7:0]  multifunction_pins,
  input  wire logic        eeprom_sync,
  input  wire logic        active_ref,
  input  wire logic        feedback_edge,
  input  wire logic [15:0] phase_target,
  output logic             ext_current_resistor_sel,
  output logic             high_freq_rx_sel,
  output logic      [1:0]  lvds_high_current,
  output logic      [1:0]  chan_enable,
  output logic      [1:0]  div_stall,
  output logic      [1:0]  div_restart,
  output logic      [15:0] phase_applied
);

  logic [7:0]    dist_set_q;
  logic [7:0]    dist_en_q;
  ccsync_ctrl_s  sync_ctrl_q;
  logic [7:0]    sync_ctrl_rsvd_q;
  logic [7:0]    auto_sync_q;
  logic [7:0]    ch_mode_q [2];
  logic [7:0]    sync_req_q;
  logic [7:0]    slew_lo_q;
  logic [7:0]    slew_hi_q;
  logic [7:0]    mfp_cfg_q [8];
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;
  logic [13:0]   idx;
  logic          wr_en;
  logic          rd_en;
  logic          mapped;
  logic [7:0]    rd_val;
  ccsync_state_e state_q;
  logic          stalling;
  logic [1:0]    chan_en_q;

  // APB decode; one wait state so read data comes from a flop
  assign idx    = paddr[15:2];
  assign rd_en  = psel & penable & ~pready_q;
  assign wr_en  = psel & penable & pready_q & pwrite;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Read mux and address map check
  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    case (idx)
      `CCSYNC_IDX_SLEW_LO:   rd_val = slew_lo_q;
      `CCSYNC_IDX_SLEW_HI:   rd_val = slew_hi_q;
      `CCSYNC_IDX_DIST_SET:  rd_val = dist_set_q;
      `CCSYNC_IDX_DIST_EN:   rd_val = dist_en_q;
      `CCSYNC_IDX_SYNC_CTRL: rd_val = {2'b00, sync_ctrl_q.source, 2'b00, sync_ctrl_q.mask};
      `CCSYNC_IDX_AUTO_SYNC: rd_val = auto_sync_q;
      `CCSYNC_IDX_CH0_MODE:  rd_val = ch_mode_q[0];
      `CCSYNC_IDX_CH1_MODE:  rd_val = ch_mode_q[1];
      `CCSYNC_IDX_SYNC_STAT: rd_val = {3'b000, chan_en_q, state_q, stalling};
      `CCSYNC_IDX_SYNC_REQ:  rd_val = sync_req_q;
      default: begin
        if (idx >= `CCSYNC_IDX_MFP_BASE && idx <= `CCSYNC_IDX_MFP_LAST) begin
          rd_val = mfp_cfg_q[idx[2:0]];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // APB answer; writes to the status register are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= rd_en;
      pslverr_q <= rd_en & ~mapped;
      if (rd_en && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_val};
      end
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dist_set_q  <= `CCSYNC_RST_REG8;
      dist_en_q   <= `CCSYNC_RST_REG8;
      sync_ctrl_q <= '0;
      auto_sync_q <= `CCSYNC_RST_REG8;
      ch_mode_q   <= '{default: `CCSYNC_RST_REG8};
      sync_req_q  <= `CCSYNC_RST_REG8;
      slew_lo_q   <= `CCSYNC_RST_REG8;
      slew_hi_q   <= `CCSYNC_RST_REG8;
      mfp_cfg_q   <= '{default: `CCSYNC_RST_REG8};
    end else if (wr_en) begin
      case (idx)
        `CCSYNC_IDX_SLEW_LO:   slew_lo_q   <= pwdata[7:0];
        `CCSYNC_IDX_SLEW_HI:   slew_hi_q   <= pwdata[7:0];
        `CCSYNC_IDX_DIST_SET:  dist_set_q  <= pwdata[7:0];
        `CCSYNC_IDX_DIST_EN:   dist_en_q   <= pwdata[7:0];
        `CCSYNC_IDX_SYNC_CTRL: sync_ctrl_q <= {pwdata[5:4], pwdata[1:0]};
        `CCSYNC_IDX_AUTO_SYNC: auto_sync_q <= pwdata[7:0];
        `CCSYNC_IDX_CH0_MODE:  ch_mode_q[0] <= pwdata[7:0];
        `CCSYNC_IDX_CH1_MODE:  ch_mode_q[1] <= pwdata[7:0];
        `CCSYNC_IDX_SYNC_REQ:  sync_req_q  <= pwdata[7:0];
        default: begin
          if (idx >= `CCSYNC_IDX_MFP_BASE && idx <= `CCSYNC_IDX_MFP_LAST) begin
            mfp_cfg_q[idx[2:0]] <= pwdata[7:0];
          end
        end
      endcase
    end
  end

  // Pin sync source: lowest numbered pin set as input with sync function wins
  logic [8:0] mfp_found;
  logic [8:0] mfp_level;
  assign mfp_found[0] = 1'b0;
  assign mfp_level[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mfp
      logic pin_is_sync;
      assign pin_is_sync = ~mfp_cfg_q[gi][`CCSYNC_BIT_MFP_DIR] &
                           (mfp_cfg_q[gi][6:0] == `CCSYNC_MFP_FUNC_SYNC); // see RULE_21
      assign mfp_found[gi+1] = mfp_found[gi] | pin_is_sync;
      assign mfp_level[gi+1] = mfp_found[gi] ? mfp_level[gi] :
                               (pin_is_sync & multifunction_pins[gi]);
    end
  endgenerate

  // Primary sync as the OR of all request sources
  logic auto_level;
  logic primary;
  logic primary_q;
  logic prim_rise;
  logic prim_fall;
  assign auto_level = (auto_sync_q[`CCSYNC_BIT_AUTO_FREQ] & freq_locked) |
                      (auto_sync_q[`CCSYNC_BIT_AUTO_PHASE] & phase_locked); // see RULE_04
  assign primary = sync_req_q[`CCSYNC_BIT_SYNC_REQ] | auto_level |
                   mfp_level[8] | eeprom_sync; // see RULE_03
  // Event is the 1-to-0 transition, so clearing the bit or a pin fall fires
  assign prim_rise = primary & ~primary_q;
  assign prim_fall = ~primary & primary_q; // see RULE_05, RULE_06

  // Reference and feedback edges are asynchronous to the divider clock
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic fb_s1_q, fb_s2_q, fb_s3_q;
  logic ref_rise;
  logic fb_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_q <= 1'b0;
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
      ref_s3_q  <= 1'b0;
      fb_s1_q   <= 1'b0;
      fb_s2_q   <= 1'b0;
      fb_s3_q   <= 1'b0;
    end else begin
      primary_q <= primary;
      ref_s1_q  <= active_ref; // see RULE_12
      ref_s2_q  <= ref_s1_q;
      ref_s3_q  <= ref_s2_q;
      fb_s1_q   <= feedback_edge;
      fb_s2_q   <= fb_s1_q;
      fb_s3_q   <= fb_s2_q;
    end
  end
  assign ref_rise = ref_s2_q & ~ref_s3_q;
  assign fb_rise  = fb_s2_q & ~fb_s3_q;

  // Sync sequencer; one alignment per request, then idle until the next rise
  logic [2:0]    rck_cnt_q;
  logic          done;
  assign stalling = (state_q != CCSYNC_IDLE);
  assign done     = (state_q == CCSYNC_RECLOCK) && (rck_cnt_q == `CCSYNC_RESTART_CYCLES);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= CCSYNC_IDLE;
      rck_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        CCSYNC_IDLE: begin
          rck_cnt_q <= 3'h0;
          if (prim_rise) begin
            case (sync_ctrl_q.source)
              CCSYNC_SRC_REF: state_q <= CCSYNC_ARMED; // see RULE_08, RULE_10
              CCSYNC_SRC_FB:  state_q <= CCSYNC_ARMED; // see RULE_09
              default:        state_q <= CCSYNC_DIRECT; // see RULE_07, RULE_22
            endcase
          end
        end
        CCSYNC_DIRECT: begin
          if (prim_fall) begin
            state_q <= CCSYNC_RECLOCK; // see RULE_07
          end
        end
        CCSYNC_ARMED: begin
          if ((sync_ctrl_q.source == CCSYNC_SRC_REF && ref_rise) ||
              (sync_ctrl_q.source == CCSYNC_SRC_FB && fb_rise)) begin
            state_q <= CCSYNC_RECLOCK; // see RULE_11
          end else if (sync_ctrl_q.source[0] == sync_ctrl_q.source[1]) begin
            state_q <= CCSYNC_RECLOCK; // Source changed to direct while armed
          end
        end
        CCSYNC_RECLOCK: begin
          rck_cnt_q <= rck_cnt_q + 3'h1;
          if (done) begin
            state_q <= CCSYNC_IDLE; // see RULE_12, RULE_13
          end
        end
        default: state_q <= CCSYNC_IDLE;
      endcase
    end
  end

  // Divider control; masked channels keep running
  logic [1:0] div_stall_q;
  logic [1:0] div_restart_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_stall_q   <= 2'b00;
      div_restart_q <= 2'b00;
    end else begin
      div_stall_q   <= (stalling && !done) ? ~sync_ctrl_q.mask : 2'b00; // see RULE_15
      div_restart_q <= done ? ~sync_ctrl_q.mask : 2'b00; // see RULE_14
    end
  end
  assign div_stall   = div_stall_q;
  assign div_restart = div_restart_q;

  // Enables move together and never mid-sync, so no runt pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_en_q <= 2'b00;
    end else if (!stalling) begin
      chan_en_q <= dist_en_q[1:0]; // see RULE_20
    end
  end
  assign chan_enable = chan_en_q;

  // Drive current and high frequency receiver selection
  logic       ext_res_q;
  logic       hf_rx_q;
  logic [1:0] lvds_hi_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_res_q <= 1'b0;
      hf_rx_q   <= 1'b0;
      lvds_hi_q <= 2'b00;
    end else begin
      ext_res_q <= dist_set_q[`CCSYNC_BIT_EXT_RES]; // see RULE_01
      hf_rx_q   <= dist_set_q[`CCSYNC_BIT_HF_RX];
      lvds_hi_q <= {ch_mode_q[1][`CCSYNC_BIT_DRIVE], ch_mode_q[0][`CCSYNC_BIT_DRIVE]}; // see RULE_02
    end
  end
  assign ext_current_resistor_sel = ext_res_q;
  assign high_freq_rx_sel         = hf_rx_q;
  assign lvds_high_current        = lvds_hi_q;

  // Phase slew limiter; a zero limit means no limit
  logic [15:0] phase_q;
  logic [15:0] slew;
  logic [16:0] diff;
  logic [15:0] mag;
  assign slew = {slew_hi_q, slew_lo_q};
  assign diff = {1'b0, phase_target} - {1'b0, phase_q};
  assign mag  = diff[16] ? 16'(~diff[15:0] + 16'h0001) : diff[15:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 16'h0000;
    end else if (slew == 16'h0000 || mag <= slew) begin
      phase_q <= phase_target;
    end else if (diff[16]) begin
      phase_q <= phase_q - slew; // see RULE_19
    end else begin
      phase_q <= phase_q + slew;
    end
  end
  assign phase_applied = phase_q;

  // Checks
  property p_direct_arm;
    @(posedge pclk) disable iff (!presetn)
      (state_q == CCSYNC_IDLE && prim_rise && !sync_ctrl_q.source[0]) |=>
        state_q == CCSYNC_DIRECT || sync_ctrl_q.source == CCSYNC_SRC_FB;
  endproperty
  a_direct_arm: assert property (p_direct_arm) else $error("direct arm missed"); // see RULE_07

  property p_armed_stalls;
    @(posedge pclk) disable iff (!presetn)
      (state_q == CCSYNC_ARMED) ##1 (state_q == CCSYNC_ARMED) |->
        div_stall_q == ~sync_ctrl_q.mask || $changed(sync_ctrl_q);
  endproperty
  a_armed_stalls: assert property (p_armed_stalls) else $error("armed not stalling"); // see RULE_10

  property p_ref_release;
    @(posedge pclk) disable iff (!presetn)
      (state_q == CCSYNC_ARMED && sync_ctrl_q.source == CCSYNC_SRC_REF && ref_rise) |=>
        state_q == CCSYNC_RECLOCK ##2 state_q == CCSYNC_RECLOCK ##1 $rose(|div_restart_q) ||
        sync_ctrl_q.mask == 2'b11;
  endproperty
  a_ref_release: assert property (p_ref_release) else $error("ref edge release wrong"); // see RULE_11

  property p_restart_latency;
    @(posedge pclk) disable iff (!presetn)
      $rose(state_q == CCSYNC_RECLOCK) |-> ##[2:2] done ##1 state_q == CCSYNC_IDLE;
  endproperty
  a_restart_latency: assert property (p_restart_latency) else $error("latency off"); // see RULE_12

  property p_one_shot;
    @(posedge pclk) disable iff (!presetn)
      (state_q == CCSYNC_IDLE && !prim_rise) |=> state_q == CCSYNC_IDLE;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("sync without request"); // see RULE_13

  property p_mask_restart;
    @(posedge pclk) disable iff (!presetn)
      done |=> div_restart_q == ~$past(sync_ctrl_q.mask) && div_stall_q == 2'b00;
  endproperty
  a_mask_restart: assert property (p_mask_restart) else $error("mask ignored"); // see RULE_14, RULE_15

  property p_enable_hold;
    @(posedge pclk) disable iff (!presetn)
      stalling |=> $stable(chan_en_q);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed mid sync"); // see RULE_20

  property p_slew_cap;
    @(posedge pclk) disable iff (!presetn)
      (slew != 16'h0000) |=>
        (16'(phase_q - $past(phase_q)) <= $past(slew)) ||
        (16'($past(phase_q) - phase_q) <= $past(slew));
  endproperty
  a_slew_cap: assert property (p_slew_cap) else $error("phase step above limit"); // see RULE_19

  property p_sync_bit_fall;
    @(posedge pclk) disable iff (!presetn)
      (state_q == CCSYNC_DIRECT && $fell(sync_req_q[`CCSYNC_BIT_SYNC_REQ]) && !primary) |=>
        state_q == CCSYNC_RECLOCK;
  endproperty
  a_sync_bit_fall: assert property (p_sync_bit_fall) else $error("bit clear not event"); // see RULE_06

endmodule : ccsync_top
`default_nettype wire

/* File: inc/ccsync_regs.svh */
// Register indices, field positions, reset values and timing counts for clock sync control
// Notes on behaviour
// (RULE_01) External resistor bit selects drive current source
// (RULE_02) Channel strength bit picks low/high LVDS current
// (RULE_03) Primary sync ORs four request sources
// (RULE_04) Lock detection raises automatic sync request
// (RULE_05) Multifunction pin falling edge is sync event
// (RULE_06) Sync bit: set, then clear triggers
// (RULE_07) Source 00: primary falling edge syncs directly
// (RULE_08) Source 01: await active reference rising edge
// (RULE_09) Source 10: await feedback rollover edge
// (RULE_10) Armed detector stalls dividers until edge
// (RULE_11) Awaited edge releases dividers, sync complete
// (RULE_12) Reclock into input clock, fixed restart delay
// (RULE_13) One alignment per request, no tracking
// (RULE_14) Masked channels ignore synchronization
// (RULE_15) Pending sync: masked run, unmasked stall
// (RULE_16) Software adjusts edge timing after sync
// (RULE_17) Software may disable outputs while adjusting
// (RULE_18) Software uses small open-loop phase steps
// (RULE_19) Slew limit caps phase change rate
// (RULE_20) Enable changes applied together, glitch free
// (RULE_21) Pin input function 69 requests sync
// (RULE_22) Source code 11 behaves as direct
`ifndef CCSYNC_REGS_SVH
`define CCSYNC_REGS_SVH

// Register indices; byte address is four times the index
`define CCSYNC_IDX_MFP_BASE      14'h0200
`define CCSYNC_IDX_MFP_LAST      14'h0207
`define CCSYNC_IDX_SLEW_LO       14'h0316
`define CCSYNC_IDX_SLEW_HI       14'h0317
`define CCSYNC_IDX_DIST_SET      14'h0400
`define CCSYNC_IDX_DIST_EN       14'h0401
`define CCSYNC_IDX_SYNC_CTRL     14'h0402
`define CCSYNC_IDX_AUTO_SYNC     14'h0403
`define CCSYNC_IDX_CH0_MODE      14'h0404
`define CCSYNC_IDX_CH1_MODE      14'h0405
`define CCSYNC_IDX_SYNC_STAT     14'h0406
`define CCSYNC_IDX_SYNC_REQ      14'h0A02

// Field positions
`define CCSYNC_BIT_HF_RX         4
`define CCSYNC_BIT_EXT_RES       5
`define CCSYNC_BIT_DRIVE         3
`define CCSYNC_BIT_SRC_LO        4
`define CCSYNC_BIT_SRC_HI        5
`define CCSYNC_BIT_AUTO_FREQ     0
`define CCSYNC_BIT_AUTO_PHASE    1
`define CCSYNC_BIT_SYNC_REQ      1
`define CCSYNC_BIT_MFP_DIR       7

// Values
`define CCSYNC_RST_REG8          8'h00
`define CCSYNC_MFP_FUNC_SYNC     7'h45
`define CCSYNC_RESTART_CYCLES    3'h2

`endif

/* File: inc/ccsync_pkg.sv */
// Types shared by the clock sync control block
package ccsync_pkg;

  typedef enum logic [1:0] {
    CCSYNC_IDLE    = 2'b00,
    CCSYNC_DIRECT  = 2'b01,
    CCSYNC_ARMED   = 2'b10,
    CCSYNC_RECLOCK = 2'b11
  } ccsync_state_e;

  typedef enum logic [1:0] {
    CCSYNC_SRC_DIRECT = 2'b00,
    CCSYNC_SRC_REF    = 2'b01,
    CCSYNC_SRC_FB     = 2'b10,
    CCSYNC_SRC_RSVD   = 2'b11
  } ccsync_src_e;

  typedef struct packed {
    ccsync_src_e source;
    logic [1:0]  mask;
  } ccsync_ctrl_s;

endpackage : ccsync_pkg

/* File: test/cosc_far_end.sv */
// Far-side model: active reference and feedback rollover edges
`timescale 1ns/1ps
`default_nettype none

module cosc_far_end (
  input  wire logic pclk,
  output var logic  active_ref,
  output var logic  feedback_edge
);
  // Both edges rest low between requests
  initial begin
    active_ref = 1'b0;
    feedback_edge = 1'b0;
  end

  // One edge launched on a pclk edge; the block resynchronises it anyway
  task automatic pulse(input logic fb, input int hi);
    @(posedge pclk);
    if (fb) feedback_edge <= 1'b1;
    else active_ref <= 1'b1;
    repeat (hi) @(posedge pclk);
    {active_ref, feedback_edge} <= 2'h0;
  endtask : pulse
endmodule : cosc_far_end
`default_nettype wire

/* File: test/clock_output_sync_control_tb.sv */
// Self-checking bench for the clock sync control block
`timescale 1ns/1ps
`default_nettype none
`include "ccsync_regs.svh"

module clock_output_sync_control_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        freq_locked, phase_locked, eeprom_sync, active_ref, feedback_edge;
  logic        ext_sel, hf_sel;
  logic [1:0]  lvds_hi, chan_en, div_stall, div_restart;
  logic [7:0]  pins;
  logic [15:0] paddr, phase_target, phase_applied;
  logic [31:0] pwdata, prdata, rd;
  int          fails = 0, compares = 0, restarts = 0, i, r0;
  localparam logic [13:0] REQ = `CCSYNC_IDX_SYNC_REQ;
  localparam logic [13:0] CTRL = `CCSYNC_IDX_SYNC_CTRL;
  logic [13:0] regs [6] = '{`CCSYNC_IDX_DIST_SET, CTRL, `CCSYNC_IDX_AUTO_SYNC,
                            `CCSYNC_IDX_CH0_MODE, `CCSYNC_IDX_CH1_MODE, REQ};

  ccsync_top i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .freq_locked, .phase_locked, .multifunction_pins(pins), .eeprom_sync,
    .active_ref, .feedback_edge, .phase_target, .ext_current_resistor_sel(ext_sel),
    .high_freq_rx_sel(hf_sel), .lvds_high_current(lvds_hi), .chan_enable(chan_en),
    .div_stall, .div_restart, .phase_applied
  );
  cosc_far_end i_far (.pclk, .active_ref, .feedback_edge);

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Restart pulses seen, so stray alignments are caught
  always @(posedge pclk) if (div_restart !== 2'h0) restarts <= restarts + 1;

  task automatic test_done();
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input string what, input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, rd, exp);
    check("pslverr", e, 1'b0);
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // Wait for the restart pulse; lo is the least latency allowed
  task automatic wrs(input string what, input logic [1:0] exp, input int lo);
    int n;
    n = 0;
    while (div_restart === 2'h0 && n < 14) begin
      @(posedge pclk);
      n++;
    end
    check(what, {n >= lo, div_restart}, {1'b1, exp});
    check("stall after restart", div_stall, 2'h0);
  endtask : wrs

  // Raise or drop one of the non-register sync sources
  task automatic drive(input int k, input logic v);
    case (k)
      0: pins[3] <= v;
      1: freq_locked <= v;
      2: phase_locked <= v;
      default: eeprom_sync <= v;
    endcase
  endtask : drive

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, eeprom_sync, freq_locked, phase_locked} = '0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    pins = 8'h00;
    phase_target = 16'h0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[k]) rdc("reset value", regs[k], 32'h00000000);
    apb(1'b0, 14'h0100, 8'h00);
    check("unmapped", e, 1'b1);
    wr(`CCSYNC_IDX_DIST_SET, 8'h30);
    wr(`CCSYNC_IDX_CH1_MODE, 8'h08);
    idle(2);
    check("drive select", {ext_sel, hf_sel, lvds_hi}, 4'hE);
    wr(`CCSYNC_IDX_CH0_MODE, 8'h08);
    idle(2);
    check("ch0 strength", lvds_hi, 2'h3);
    rdc("settings", `CCSYNC_IDX_DIST_SET, 32'h00000030);
    wr(CTRL, 8'hFF);
    rdc("sync ctrl", CTRL, 32'h00000033);
    // Direct source 00, then reserved 11 with channel 0 masked
    for (i = 0; i < 2; i++) begin
      wr(CTRL, i ? 8'h31 : 8'h00);
      r0 = restarts;
      wr(REQ, 8'h02);
      idle(4);
      check("stall on set", div_stall, i ? 2'h2 : 2'h3);
      check("early restart", restarts, r0);
      wr(REQ, 8'h00);
      wrs("direct restart", i ? 2'h2 : 2'h3, 2);
    end
    // Reference edge source, then feedback source with channel 1 masked
    for (i = 0; i < 2; i++) begin
      wr(CTRL, i ? 8'h22 : 8'h10);
      wr(REQ, 8'h02);
      wr(REQ, 8'h00);
      idle(20);
      check("armed stall", div_stall, i ? 2'h1 : 2'h3);
      rdc("armed status", `CCSYNC_IDX_SYNC_STAT, 32'h00000005);
      i_far.pulse(i == 0, 8);
      idle(10);
      check("wrong edge", div_stall, i ? 2'h1 : 2'h3);
      i_far.pulse(i != 0, 3);
      wrs("edge restart", i ? 2'h1 : 2'h3, 0);
      // Let the restart just seen land in the counter first
      idle(1);
      r0 = restarts;
      i_far.pulse(i != 0, 3);
      idle(12);
      check("one time sync", restarts, r0);
    end
    // Pin, lock and loader sources
    wr(CTRL, 8'h00);
    wr(`CCSYNC_IDX_AUTO_SYNC, 8'h03);
    wr(`CCSYNC_IDX_MFP_BASE + 14'h0003, 8'h45);
    for (i = 0; i < 4; i++) begin
      drive(i, 1'b1);
      idle(6);
      check("source stall", div_stall, 2'h3);
      drive(i, 1'b0);
      wrs("source restart", 2'h3, 2);
    end
    wr(`CCSYNC_IDX_DIST_EN, 8'h03);
    idle(3);
    check("enable", chan_en, 2'h3);
    // Outputs off while phase moves, after the sync
    wr(`CCSYNC_IDX_DIST_EN, 8'h00);
    wr(`CCSYNC_IDX_SLEW_LO, 8'h01);
    phase_target <= 16'h0004;
    idle(2);
    check("slew step", phase_applied, 16'h0001);
    idle(10);
    check("slew done", phase_applied, 16'h0004);
    test_done();
  end

  // Run takes under four hundred cycles; give it a hundred times that
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule : clock_output_sync_control_tb
`default_nettype wire
